// File: pkg/ris_cfg.svh
// Purpose: constants of the reset and interrupt sequencer
// Assumes: aclk is the oscillator reference clock, 50 MHz
// Notes:   cycle counts are in aclk cycles
`ifndef RIS_CFG_SVH
`define RIS_CFG_SVH
// recovery timing, osc_ref_clock cycles
`define RIS_STAB_CYC   4096
`define RIS_DRIVE_CYC  32
`define RIS_HOLD_CYC   32
`define RIS_EXT_MIN    8
`define RIS_WDOG_BITS  18
// cpu address map
`define RIS_RST_VEC    16'hFFFE
`define RIS_TRAP_VEC   16'hFFFC
`define RIS_WDOG_ADDR  16'hFFFF
// register offsets
`define RIS_OFF_CAUSE  8'h00
`define RIS_OFF_CTRL   8'h04
`define RIS_OFF_STAT   8'h08
// reset_cause_flags bit positions
`define RIS_F_POR      7
`define RIS_F_PIN      6
`define RIS_F_WDOG     5
`define RIS_F_OPC      4
`define RIS_F_ADR      3
`define RIS_F_BRN      1
// control bits and reset values
`define RIS_C_STOPEN   0
`define RIS_CTRL_RST   1'b0
// stack steps, high index byte never stacked; axi response codes
`define RIS_PUSH_N     3'h5
`define RIS_OK         2'h0
`define RIS_SLVERR     2'h2
`endif

// File: pkg/ris_pkg.sv
// Purpose: types of the reset and interrupt sequencer
// Assumes: AXI4-Lite with 32-bit data
// Notes:   state is one packed struct
package ris_pkg;
    typedef enum logic [5:0] {
        RST_STAB  = 6'h01,
        RST_BROWN = 6'h02,
        RST_DRIVE = 6'h04,
        RST_HOLD  = 6'h08,
        RST_EXT   = 6'h10,
        RST_RUN   = 6'h20
    } ris_rst_e;
    typedef enum logic [2:0] {
        INT_IDLE = 3'h1,
        INT_PUSH = 3'h2,
        INT_VEC  = 3'h4
    } ris_int_e;
    typedef struct packed {
        logic        awvalid;
        logic [7:0]  awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [7:0]  araddr;
        logic        rready;
    } ris_axi_req_s;
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } ris_axi_rsp_s;
    typedef struct packed {
        logic        instr_done;
        logic        rti_done;
        logic        rti_imask;
        logic        sei;
        logic        cli;
        logic        swi_exec;
        logic        op_fetch;
        logic        op_illegal;
        logic        stop_exec;
        logic        addr_unmapped;
        logic        wr_valid;
        logic [15:0] wr_addr;
        logic        pll_select;
    } ris_cpu_s;
    typedef struct packed {
        ris_rst_e    rst_st;
        logic [12:0] cnt;
        logic [7:0]  cause;
        logic [7:0]  flags;
        logic        stop_en;
        logic        div4_sel;
        logic [19:0] wdog;
        logic [2:0]  pin_s;
        logic        pin_f;
        logic [2:0]  bo_s;
        logic        bo_f;
        logic [7:0]  ext_cnt;
        ris_int_e    int_st;
        logic [2:0]  step;
        logic [3:0]  prio;
        logic        imask;
        logic [15:0] vec_addr;
        logic        vec_load;
        logic        push;
        logic        flush;
        logic        aw_ok;
        logic [7:0]  awaddr;
        logic        w_ok;
        logic [7:0]  wdata;
        logic        wstrb0;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
    } ris_st_s;
endpackage : ris_pkg

// File: rtl/ris_seq.sv
// Purpose: reset recovery sequencing and cpu interrupt entry
// Assumes: aclk is osc_ref_clock; aresetn low is power-up
// Notes:   registers over AXI4-Lite; reset pin is open drain
// Functional notes
// R1: any reset aborts, then loads vector FFFE
// R2: bus clock is osc_ref_clock over four
// R3: long external low resets, sets pin flag
// R4: internal sources drive pin 32 cycles
// R5: hold device reset 32 more cycles
// R6: power-up gates clocks 4096 cycles, pin low
// R7: pin free at 32, fetch at 64
// R8: power-up sets own flag, clears others
// R9: watchdog overflow resets, sets watchdog flag
// R10: any write to FFFF clears watchdog
// R11: brownout holds pin, then power-up timing
// R12: illegal opcode resets, sets bad_opcode_flag
// R13: stop with stop enable 0 is illegal
// R14: unmapped fetch resets; data access does not
// R15: six flags, read-only, cleared by read
// R16: later source may drop earlier flag
// R17: interrupts wait for instruction completion
// R18: stack registers, load vector; return restores
// R19: high index byte is never stacked
// R20: entry sets global mask, no preemption
// R21: highest priority pending wins at boundary
// R22: pending after return served before main
// R23: global mask spares only software trap
// R24: flags in fixed bits, rest zero
`include "ris_cfg.svh"
module ris_seq
    import ris_pkg::*;
#(
    parameter int STAB_CYC  = `RIS_STAB_CYC,
    parameter int DRIVE_CYC = `RIS_DRIVE_CYC,
    parameter int HOLD_CYC  = `RIS_HOLD_CYC,
    parameter int EXT_MIN   = `RIS_EXT_MIN,
    parameter int WDOG_BITS = `RIS_WDOG_BITS
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire ris_axi_req_s axi_req,
    output ris_axi_rsp_s      axi_rsp,
    input  wire ris_cpu_s     cpu,
    input  wire logic [15:1]  irq_req,
    input  wire logic         brownout_in,
    input  wire logic         rst_pin_in,
    output logic              rst_pin_out,
    output logic              rst_pin_oe_n,
    output logic              cpu_reset,
    output logic              clk_gate_n,
    output logic              bus_div4_sel,
    output logic              vec_load,
    output logic [15:0]       vec_addr,
    output logic              stack_push,
    output logic [2:0]        stack_sel,
    output logic              prefetch_flush,
    output logic              imask
);
    // refuse sizes that the counters cannot hold
    if (STAB_CYC < 1 || STAB_CYC > 8192 || DRIVE_CYC < 1 || DRIVE_CYC > 8192 ||
        HOLD_CYC < 1 || HOLD_CYC > 8192 || EXT_MIN < 4 || EXT_MIN > 255 ||
        WDOG_BITS < 2 || WDOG_BITS > 20) begin : g_param_chk
        $error("ris_seq: parameter out of range");
    end

    localparam logic [12:0] STAB_L  = 13'(STAB_CYC - 1);
    localparam logic [12:0] DRIVE_L = 13'(DRIVE_CYC - 1);
    localparam logic [12:0] HOLD_L  = 13'(HOLD_CYC - 1);
    localparam logic [7:0]  EXT_L   = 8'(EXT_MIN - 1);
    localparam logic [19:0] WDOG_L  = 20'((64'h1 << WDOG_BITS) - 1);

    ris_st_s r_reg;
    ris_st_s r_next;

    logic       drive_pin;
    logic       src_int;
    logic [7:0] src_bit;
    logic [3:0] pick;
    logic       take;
    logic       rd_hit;
    logic       wr_go;

    // open-drain pin driven during internal recovery
    assign drive_pin    = r_reg.rst_st inside {RST_STAB, RST_BROWN, RST_DRIVE}; // [R4] [R6] [R11]
    assign rst_pin_out  = 1'b0;
    assign rst_pin_oe_n = !drive_pin;
    assign cpu_reset    = r_reg.rst_st != RST_RUN; // [R1] [R5]
    assign clk_gate_n   = !(r_reg.rst_st inside {RST_STAB, RST_BROWN}); // [R6]
    assign bus_div4_sel = r_reg.div4_sel;
    assign vec_load     = r_reg.vec_load;
    assign vec_addr     = r_reg.vec_addr;
    assign stack_push   = r_reg.push;
    assign stack_sel    = r_reg.step;
    assign prefetch_flush = r_reg.flush;
    assign imask        = r_reg.imask;

    // axi handshake outputs
    assign axi_rsp.awready = !r_reg.aw_ok && !r_reg.bvalid;
    assign axi_rsp.wready  = !r_reg.w_ok && !r_reg.bvalid;
    assign axi_rsp.bvalid  = r_reg.bvalid;
    assign axi_rsp.bresp   = r_reg.bresp;
    assign axi_rsp.arready = !r_reg.rvalid;
    assign axi_rsp.rvalid  = r_reg.rvalid;
    assign axi_rsp.rdata   = r_reg.rdata;
    assign axi_rsp.rresp   = r_reg.rresp;

    // internal reset sources seen by the cpu
    always_comb begin
        src_bit = 8'h00;
        if (r_reg.rst_st == RST_RUN) begin
            if (r_reg.wdog == WDOG_L)
                src_bit[`RIS_F_WDOG] = 1'b1; // [R9]
            if (cpu.op_fetch && (cpu.op_illegal || (cpu.stop_exec && !r_reg.stop_en)))
                src_bit[`RIS_F_OPC] = 1'b1; // [R12] [R13]
            if (cpu.op_fetch && cpu.addr_unmapped)
                src_bit[`RIS_F_ADR] = 1'b1; // [R14]
        end
        src_int = |src_bit;
    end

    // priority pick, lowest index first, trap is zero
    always_comb begin
        pick = 4'h0;
        for (int i = 15; i >= 1; i--) begin
            if (irq_req[i])
                pick = 4'(i); // [R21]
        end
        if (cpu.swi_exec)
            pick = 4'h0;
        // on a return the stacked mask bit decides, so a pending source goes first
        take = (cpu.instr_done || cpu.rti_done) &&
               (cpu.swi_exec || (|irq_req && !(cpu.rti_done ? cpu.rti_imask : r_reg.imask))); // [R17] [R22] [R23]
    end

    assign rd_hit = axi_req.arvalid && !r_reg.rvalid;
    assign wr_go  = r_reg.aw_ok && r_reg.w_ok && !r_reg.bvalid;

    // next state
    always_comb begin
        r_next = r_reg;
        r_next.vec_load = 1'b0;
        r_next.push     = 1'b0;
        r_next.flush    = 1'b0;
        // three-stage pin filters
        r_next.pin_s = {r_reg.pin_s[1:0], rst_pin_in};
        if (r_reg.pin_s[1] == r_reg.pin_s[2])
            r_next.pin_f = r_reg.pin_s[2];
        r_next.bo_s = {r_reg.bo_s[1:0], brownout_in};
        if (r_reg.bo_s[1] == r_reg.bo_s[2])
            r_next.bo_f = r_reg.bo_s[2];
        // external low length while not driven by us
        if (!r_reg.pin_f && !drive_pin && r_reg.ext_cnt != 8'hFF)
            r_next.ext_cnt = r_reg.ext_cnt + 8'h01;
        else if (r_reg.pin_f)
            r_next.ext_cnt = 8'h00;
        // watchdog counter runs only while the cpu runs
        if (r_reg.rst_st != RST_RUN ||
            (cpu.wr_valid && cpu.wr_addr == `RIS_WDOG_ADDR)) // [R10]
            r_next.wdog = 20'h0;
        else
            r_next.wdog = r_reg.wdog + 20'h1;
        r_next.cnt = r_reg.cnt + 13'h1;
        // flags clear on read; a set below still wins
        if (rd_hit && axi_req.araddr == `RIS_OFF_CAUSE)
            r_next.flags = 8'h00; // [R15]
        unique case (r_reg.rst_st)
            RST_STAB: begin
                if (r_reg.cnt == STAB_L) begin
                    r_next.rst_st = RST_DRIVE; // [R6]
                    r_next.cnt = 13'h0;
                end
            end
            RST_BROWN: begin
                r_next.cnt = 13'h0;
                if (!r_reg.bo_f)
                    r_next.rst_st = RST_STAB; // [R11]
            end
            RST_DRIVE: begin
                if (r_reg.cnt == DRIVE_L) begin
                    r_next.rst_st = RST_HOLD; // [R4] [R7]
                    r_next.cnt = 13'h0;
                end
            end
            RST_EXT: begin
                r_next.cnt = 13'h0;
                if (r_reg.pin_f)
                    r_next.rst_st = RST_HOLD;
            end
            RST_HOLD: begin
                if (r_reg.cnt == HOLD_L) begin
                    r_next.rst_st = RST_RUN; // [R5] [R7]
                    r_next.vec_load = 1'b1; // [R1]
                    r_next.vec_addr = `RIS_RST_VEC;
                    if (r_reg.cause[`RIS_F_POR])
                        r_next.flags = r_reg.cause; // [R8]
                    else
                        r_next.flags = r_next.flags | r_reg.cause;
                end
            end
            RST_RUN: begin
                r_next.cnt = 13'h0;
                if (cpu.pll_select)
                    r_next.div4_sel = 1'b0;
            end
        endcase
        // new sources restart recovery; later cause replaces earlier
        if (r_reg.rst_st != RST_STAB && r_reg.rst_st != RST_BROWN) begin
            if (src_int) begin
                r_next.rst_st = RST_DRIVE; // [R16]
                r_next.cnt = 13'h0;
                r_next.cause = src_bit;
            end else if (r_reg.ext_cnt == EXT_L && !r_reg.pin_f) begin
                r_next.rst_st = RST_EXT; // [R3]
                r_next.cause = 8'h00;
                r_next.cause[`RIS_F_PIN] = 1'b1;
            end
        end
        if (r_reg.bo_f) begin
            r_next.rst_st = RST_BROWN; // [R11]
            r_next.cause = 8'h00;
            r_next.cause[`RIS_F_BRN] = 1'b1;
        end
        // any reset: abort, slow bus clock, mask on
        if (r_next.rst_st != RST_RUN) begin
            r_next.div4_sel = 1'b1; // [R2]
            r_next.int_st = INT_IDLE; // [R1]
            r_next.imask = 1'b1;
            r_next.step = 3'h0;
        end else begin
            unique case (r_reg.int_st)
                INT_IDLE: begin
                    if (cpu.sei)
                        r_next.imask = 1'b1;
                    else if (cpu.cli)
                        r_next.imask = 1'b0;
                    else if (cpu.rti_done)
                        r_next.imask = cpu.rti_imask; // [R18]
                    if (take) begin
                        r_next.int_st = INT_PUSH;
                        r_next.prio = pick; // [R21]
                        r_next.imask = 1'b1; // [R20]
                        r_next.flush = cpu.rti_done; // [R22]
                        r_next.step = 3'h0;
                    end
                end
                INT_PUSH: begin
                    // pc low, pc high, x, a, ccr; h left off
                    r_next.push = 1'b1; // [R18] [R19]
                    r_next.step = r_reg.step + 3'h1;
                    if (r_reg.step == `RIS_PUSH_N - 3'h1)
                        r_next.int_st = INT_VEC;
                end
                INT_VEC: begin
                    r_next.vec_load = 1'b1; // [R18]
                    r_next.vec_addr = `RIS_TRAP_VEC - {11'h0, r_reg.prio, 1'b0};
                    r_next.int_st = INT_IDLE;
                    r_next.step = 3'h0;
                end
            endcase
        end
        // axi write path
        if (axi_req.awvalid && !r_reg.aw_ok && !r_reg.bvalid) begin
            r_next.aw_ok = 1'b1;
            r_next.awaddr = axi_req.awaddr;
        end
        if (axi_req.wvalid && !r_reg.w_ok && !r_reg.bvalid) begin
            r_next.w_ok = 1'b1;
            r_next.wdata = axi_req.wdata[7:0];
            r_next.wstrb0 = axi_req.wstrb[0];
        end
        if (wr_go) begin
            r_next.aw_ok = 1'b0;
            r_next.w_ok = 1'b0;
            r_next.bvalid = 1'b1;
            r_next.bresp = `RIS_OK;
            if (r_reg.awaddr == `RIS_OFF_CTRL) begin
                if (r_reg.wstrb0)
                    r_next.stop_en = r_reg.wdata[`RIS_C_STOPEN];
            end else if (r_reg.awaddr != `RIS_OFF_CAUSE && r_reg.awaddr != `RIS_OFF_STAT)
                r_next.bresp = `RIS_SLVERR;
        end
        if (r_reg.bvalid && axi_req.bready)
            r_next.bvalid = 1'b0;
        // axi read path, one cycle answer
        if (rd_hit) begin
            r_next.rvalid = 1'b1;
            r_next.rresp = `RIS_OK;
            r_next.rdata = 32'h0;
            unique case (axi_req.araddr)
                `RIS_OFF_CAUSE: r_next.rdata[7:0] = r_reg.flags; // [R24]
                `RIS_OFF_CTRL:  r_next.rdata[0] = r_reg.stop_en;
                `RIS_OFF_STAT:  r_next.rdata[15:0] = {r_reg.prio, 1'b0, r_reg.int_st,
                                                     r_reg.imask, r_reg.div4_sel, r_reg.rst_st};
                default:        r_next.rresp = `RIS_SLVERR;
            endcase
        end else if (r_reg.rvalid && axi_req.rready)
            r_next.rvalid = 1'b0;
    end

    // register the state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r_reg <= '0;
            r_reg.rst_st <= RST_STAB; // [R6]
            r_reg.int_st <= INT_IDLE;
            r_reg.cause <= 8'h80;
            r_reg.pin_s <= 3'h7;
            r_reg.pin_f <= 1'b1;
            r_reg.imask <= 1'b1;
            r_reg.div4_sel <= 1'b1;
            r_reg.stop_en <= `RIS_CTRL_RST;
            r_reg.vec_addr <= `RIS_RST_VEC;
        end else begin
            r_reg <= r_next;
        end
    end

    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_push5;
        stack_push [*5];
    endsequence

    AST_PIN_DRV: assert property (r_reg.rst_st == RST_DRIVE |-> !rst_pin_oe_n && cpu_reset) // [R4]
        else $error("pin not driven in drive phase");
    AST_HOLD_REL: assert property ($rose(r_reg.rst_st == RST_HOLD) && !r_reg.bo_f
        |-> rst_pin_oe_n && cpu_reset) // [R5]
        else $error("hold phase drives pin");
    AST_CLK_GATE: assert property (r_reg.rst_st == RST_STAB |-> !clk_gate_n && !rst_pin_oe_n) // [R6]
        else $error("clocks run during stabilisation");
    AST_RST_VEC: assert property ($rose(r_reg.rst_st == RST_RUN) |-> vec_load && vec_addr == 16'hFFFE) // [R1]
        else $error("reset vector not loaded");
    AST_POR_FLAG: assert property ($rose(r_reg.rst_st == RST_RUN) && $past(r_reg.cause) == 8'h80
        |-> r_reg.flags == 8'h80) // [R8]
        else $error("power-up flags wrong");
    AST_DIV4: assert property (cpu_reset |=> bus_div4_sel) // [R2]
        else $error("bus clock not divided by four");
    AST_RD_CLR: assert property (rd_hit && axi_req.araddr == 8'h00 && r_next.rst_st == r_reg.rst_st
        |=> r_reg.flags == 8'h00 && axi_rsp.rvalid && axi_rsp.rdata[7:0] == $past(r_reg.flags)) // [R15]
        else $error("cause read did not clear");
    // entry: mask at once, five pushes a cycle later, then the vector
    AST_ENTRY: assert property (r_reg.int_st == INT_IDLE && take && r_next.rst_st == RST_RUN // [R18] [R20]
        |=> imask ##1 s_push5 ##1 vec_load)
        else $error("interrupt entry sequence wrong");
    AST_NO_TAKE: assert property (r_reg.rst_st == RST_RUN && !cpu.instr_done && !cpu.rti_done
        && r_reg.int_st == INT_IDLE |=> r_reg.int_st == INT_IDLE) // [R17]
        else $error("interrupt taken mid instruction");
    AST_MASKED: assert property (imask && !cpu.swi_exec && !(cpu.rti_done && !cpu.rti_imask)
        && r_reg.int_st == INT_IDLE |=> r_reg.int_st == INT_IDLE) // [R23]
        else $error("masked interrupt taken");

    // source entry, watchdog service, trap and return details
    AST_SRC_DRIVE: assert property (r_reg.rst_st == RST_RUN && src_int && !r_reg.bo_f // [R9] [R12] [R14]
        |=> r_reg.rst_st == RST_DRIVE && !rst_pin_oe_n)
        else $error("internal source did not drive the pin");
    AST_WDOG_CLR: assert property (r_reg.rst_st == RST_RUN && cpu.wr_valid && cpu.wr_addr == 16'hFFFF // [R10]
        |=> r_reg.wdog == 20'h0)
        else $error("watchdog not cleared by write");
    AST_DATA_FETCH: assert property (r_reg.rst_st == RST_RUN && !cpu.op_fetch // [R14]
        |-> !src_bit[`RIS_F_ADR] && !src_bit[`RIS_F_OPC])
        else $error("data access raised a reset source");
    AST_BROWN: assert property (r_reg.bo_f // [R11]
        |=> r_reg.rst_st == RST_BROWN && !rst_pin_oe_n && !clk_gate_n)
        else $error("brownout did not hold the pin");
    AST_TRAP: assert property (r_reg.rst_st == RST_RUN && r_reg.int_st == INT_IDLE && cpu.instr_done // [R23]
        && cpu.swi_exec && r_next.rst_st == RST_RUN |=> r_reg.int_st == INT_PUSH && imask)
        else $error("software trap not taken");
    AST_FLUSH: assert property (r_reg.int_st == INT_IDLE && take && cpu.rti_done // [R22]
        && r_next.rst_st == RST_RUN |=> prefetch_flush)
        else $error("prefetch not flushed after return");

endmodule : ris_seq

// File: tb/ris_pin_partner.sv
// Purpose: far side of the shared open-drain reset line
// Assumes: line has a pull-up; released line reads high
// Notes:   go loads a hold count; the model pulls low while it runs
module ris_pin_partner (
    input  wire logic       aclk,
    input  wire logic       go,
    input  wire logic [7:0] hold_cyc,
    input  wire logic       dut_out,
    input  wire logic       dut_oe_n,
    output logic            pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt_reg = 8'h00;
    // count down a commanded hold of the line, short or long
    always @(posedge aclk) begin
        if (go) cnt_reg <= hold_cyc;
        else if (cnt_reg != 8'h00) cnt_reg <= cnt_reg - 8'h01;
    end
    // wired-and with pull-up: low when any party pulls
    assign pin = !((!dut_oe_n && !dut_out) || (cnt_reg != 8'h00));
endmodule : ris_pin_partner

// File: tb/tb.sv
// Purpose: self-checking bench of the reset and interrupt sequencer
// Assumes: short stabilization count and watchdog width
// Notes:   watchdog is kicked in the background unless a test stops it
module tb
    import ris_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    localparam int STAB = 16;
    localparam int DRV  = 32;
    localparam int HLD  = 32;
    logic         aclk    = 1'b0;
    logic         aresetn = 1'b0;
    logic         brown   = 1'b0;
    logic         go      = 1'b0;
    logic         kick    = 1'b1;
    logic         kick_v  = 1'b0;
    logic [7:0]   plen    = 8'h00;
    logic [15:1]  irq     = '0;
    ris_axi_req_s req     = '0;
    ris_cpu_s     cpu     = '{wr_addr: 16'hFFFF, default: '0};
    ris_axi_rsp_s rsp;
    ris_cpu_s     cpu_d;
    logic         pin, pout, poe_n, crst, cgate_n, div4, vld, push, flush, imask;
    logic [15:0]  vaddr;
    logic [2:0]   sel;
    logic [31:0]  d;
    logic [1:0]   r;
    logic [15:1]  rq;
    int           errors = 0, samples_checked = 0, cyc = 0, seed = 67, mflags = 0, mmask = 1;
    int           lo, g, hd;
    always #10 aclk = ~aclk;
    // background watchdog service writes
    always @(posedge aclk) kick_v <= kick & ~kick_v;
    always_comb begin
        cpu_d = cpu;
        cpu_d.wr_valid = kick_v;
    end
    ris_seq #(.STAB_CYC(STAB), .WDOG_BITS(4)) dut (
        .aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp), .cpu(cpu_d), .irq_req(irq),
        .brownout_in(brown), .rst_pin_in(pin), .rst_pin_out(pout), .rst_pin_oe_n(poe_n), .cpu_reset(crst),
        .clk_gate_n(cgate_n), .bus_div4_sel(div4), .vec_load(vld), .vec_addr(vaddr), .stack_push(push),
        .stack_sel(sel), .prefetch_flush(flush), .imask(imask));
    ris_pin_partner u_far (.aclk(aclk), .go(go), .hold_cyc(plen), .dut_out(pout), .dut_oe_n(poe_n), .pin(pin));
    task chk(input logic [31:0] gv, input logic [31:0] ev);
        samples_checked++;
        if (gv !== ev) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, gv, ev);
        end
    endtask : chk
    task results;
        if (errors == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : results
    // hang guard
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            errors++;
            results();
        end
    end
    // axi4-lite write: address and data together, each released when taken
    task axw(input logic [7:0] a, input logic [31:0] wd, output logic [1:0] rs);
        @(posedge aclk);
        req <= '{awvalid: 1'b1, awaddr: a, wvalid: 1'b1, wdata: wd, wstrb: 4'hF, bready: 1'b1, default: '0};
        do begin
            @(posedge aclk);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
        end while (rsp.bvalid !== 1'b1);
        rs = rsp.bresp;
        req.bready <= 1'b0;
    endtask : axw
    // axi4-lite read
    task axr(input logic [7:0] a, output logic [31:0] rd, output logic [1:0] rs);
        @(posedge aclk);
        req <= '{arvalid: 1'b1, araddr: a, rready: 1'b1, default: '0};
        do begin
            @(posedge aclk);
            if (rsp.arready) req.arvalid <= 1'b0;
        end while (rsp.rvalid !== 1'b1);
        rd = rsp.rdata;
        rs = rsp.rresp;
        req.rready <= 1'b0;
    endtask : axr
    // one-cycle cpu event
    task pulse(input ris_cpu_s m);
        @(posedge aclk);
        cpu <= cpu | m;
        @(posedge aclk);
        cpu <= cpu & ~m;
    endtask : pulse
    // model of the cause flags: power-up replaces, others add, read clears
    task cause(input int b);
        mflags = (b == 7) ? 32'h80 : (mflags | (1 << b));
        axr(8'h00, d, r);
        chk(d, mflags);
        chk(r, 2'h0);
        mflags = 0;
    endtask : cause
    // measures line drive, gated and hold cycles of one recovery
    task recov(output int l, output int gc, output int h);
        l = 0;
        gc = 0;
        h = 0;
        // count only the cycles that show each level
        @(negedge aclk);
        for (int i = 0; i < 60 && crst !== 1'b1; i++) @(negedge aclk);
        while (poe_n === 1'b0 && l < 900) begin
            l++;
            gc += (cgate_n === 1'b0);
            @(negedge aclk);
        end
        while (crst === 1'b1 && h < 900) begin
            h++;
            @(negedge aclk);
        end
        chk(vld, 1'b1);
        chk(vaddr, 16'hFFFE);
        chk(div4, 1'b1);
    endtask : recov
    task no_rst(input int n);
        repeat (n) begin
            @(negedge aclk);
            chk(crst, 1'b0);
        end
    endtask : no_rst
    task unmask;
        pulse('{cli: 1'b1, default: '0});
        mmask = 0;
    endtask : unmask
    // interrupt request, then boundary event; model picks lowest index
    task irq_t(input logic [15:1] q, input logic software_trap_instruction, input logic return_from_interrupt);
        int n, pv;
        logic [15:0] got;
        logic hit, fl;
        n = 0;
        pv = 0;
        hit = 0;
        fl = 0;
        got = 16'h0000;
        for (int i = 15; i >= 1; i--) if (q[i]) pv = i;
        if (software_trap_instruction) pv = 0;
        @(posedge aclk);
        irq <= q;
        repeat (3) begin
            @(negedge aclk);
            chk(vld | push, 1'b0);
        end
        pulse('{instr_done: !return_from_interrupt, rti_done: return_from_interrupt, swi_exec: software_trap_instruction, default: '0});
        irq <= '0;
        repeat (10) begin
            @(negedge aclk);
            if (push === 1'b1) begin
                chk(sel, n + 1);
                n++;
            end
            if (vld === 1'b1) begin
                hit = 1;
                got = vaddr;
            end
            fl |= flush;
        end
        if (software_trap_instruction || (q != 0 && (return_from_interrupt || mmask == 0))) begin
            chk(n, 5);
            chk(got, 16'hFFFC - 2 * pv);
            chk(fl, return_from_interrupt);
            chk(imask, 1'b1);
            mmask = 1;
        end else begin
            chk(hit, 1'b0);
        end
    endtask : irq_t
    initial begin
        repeat (3) @(posedge aclk);
        @(negedge aclk);
        chk({poe_n, cgate_n, crst}, 3'b001);
        @(posedge aclk);
        aresetn <= 1'b1;
        recov(lo, g, hd);
        chk(g >= STAB && g <= STAB + 1, 1);
        chk(lo - g, DRV);
        chk(hd, HLD);
        cause(7);
        axr(8'h00, d, r);
        chk(d, 0);
        axw(8'h00, 32'hFF, r);
        chk(r, 2'h0);
        axr(8'h00, d, r);
        chk(d, 0);
        axw(8'h0C, 32'h1, r);
        chk(r, 2'h2);
        axr(8'h0C, d, r);
        chk(d, 0);
        chk(r, 2'h2);
        axw(8'h04, 32'h1, r);
        axr(8'h04, d, r);
        chk(d[0], 1'b1);
        pulse('{op_fetch: 1'b1, stop_exec: 1'b1, default: '0});
        pulse('{addr_unmapped: 1'b1, default: '0});
        @(posedge aclk);
        plen <= 8'h03;
        go <= 1'b1;
        @(posedge aclk);
        go <= 1'b0;
        no_rst(40);
        axw(8'h04, 32'h0, r);
        pulse('{op_fetch: 1'b1, stop_exec: 1'b1, default: '0});
        recov(lo, g, hd);
        chk(lo, DRV);
        chk(hd, HLD);
        cause(4);
        pulse('{op_fetch: 1'b1, op_illegal: 1'b1, default: '0});
        recov(lo, g, hd);
        cause(4);
        pulse('{op_fetch: 1'b1, addr_unmapped: 1'b1, default: '0});
        recov(lo, g, hd);
        cause(3);
        pulse('{pll_select: 1'b1, default: '0});
        kick <= 1'b0;
        recov(lo, g, hd);
        kick <= 1'b1;
        chk(lo, DRV);
        chk(hd, HLD);
        cause(5);
        @(posedge aclk);
        plen <= 8'd20;
        go <= 1'b1;
        @(posedge aclk);
        go <= 1'b0;
        recov(lo, g, hd);
        chk(lo, 0);
        cause(6);
        @(posedge aclk);
        brown <= 1'b1;
        repeat (10) @(posedge aclk);
        brown <= 1'b0;
        recov(lo, g, hd);
        // four filter edges and one state edge before stabilisation starts
        chk(lo, STAB + DRV + 5);
        chk(hd, HLD);
        cause(1);
        for (int k = 0; k < 5; k++) begin
            rq = 15'($random(seed));
            if (rq == 0) rq = 15'h4000;
            unmask();
            irq_t(rq, 1'b0, 1'b0);
        end
        irq_t(15'h0004, 1'b0, 1'b0);
        irq_t(15'h0002, 1'b1, 1'b0);
        // mask still set; the return's stacked bit clears it
        irq_t(15'h0100, 1'b0, 1'b1);
        results();
    end
endmodule : tb
